// >>> astx_pkg.sv
package astx_pkg;
    // APB address width; byte address is four times a register index
    localparam int ADDR_W = 26;
    // Register indices
    localparam logic [23:0] IDX_IRCTL  = 24'hFF05DE;
    localparam logic [23:0] IDX_MODE   = 24'hFF05D0;
    localparam logic [23:0] IDX_CTRL   = 24'hFF05D1;
    localparam logic [23:0] IDX_BRATE  = 24'hFF05D2;
    localparam logic [23:0] IDX_TXDATA = 24'hFF05D3;
    localparam logic [23:0] IDX_STATUS = 24'hFF05D4;
    localparam logic [23:0] IDX_RXDATA = 24'hFF05D5;
    // Infrared control fields
    localparam int IR_EN  = 7;
    localparam int IR_WLO = 4;
    localparam int IR_TXI = 3;
    localparam int IR_RXI = 2;
    localparam logic [7:0] IRCTL_RST = 8'h03;
    localparam logic [1:0] IR_RSVD   = 2'h3;
    // Pulse width codes, and the bit-relative width in sixteenths of a bit
    localparam logic [2:0] IRW_BIT = 3'h0;
    localparam logic [2:0] IRW_D2  = 3'h1;
    localparam logic [2:0] IRW_D4  = 3'h2;
    localparam logic [2:0] IRW_D8  = 3'h3;
    localparam logic [2:0] IRW_D16 = 3'h4;
    localparam logic [3:0] IR_BIT_PH = 4'h3;
    // Mode fields
    localparam int MD_CHR7 = 6;
    localparam int MD_PEN  = 5;
    localparam int MD_ODD  = 4;
    localparam int MD_STP2 = 3;
    // Control fields
    localparam int CT_TIE  = 7;
    localparam int CT_TE   = 5;
    localparam int CT_RE   = 4;
    localparam int CT_TX_DONE_IRQ_ENABLE = 3;
    localparam int CT_SCKP = 2;
    localparam int CT_CLOCK_ENABLE_HIGH = 1;
    localparam int CT_CLOCK_ENABLE_LOW = 0;
    // Status fields
    localparam int ST_TX_BUFFER_EMPTY_FLAG = 7;
    localparam int ST_RX_FULL_FLAG = 6;
    localparam int ST_OER  = 5;
    localparam int ST_FER  = 4;
    localparam int ST_PER  = 3;
    localparam int ST_TX_DONE_FLAG = 2;
    // Oversampling points
    localparam logic [3:0] PH_LAST = 4'hF;
    localparam logic [3:0] PH_MID  = 4'h7;
    // Transmit and receive sequencer states
    typedef enum logic [4:0] {
        TX_IDLE = 5'h01, TX_START = 5'h02, TX_DATA = 5'h04, TX_PAR = 5'h08, TX_STOP = 5'h10
    } astx_tx_e;
    typedef enum logic [4:0] {
        RX_IDLE = 5'h01, RX_START = 5'h02, RX_DATA = 5'h04, RX_PAR = 5'h08, RX_STOP = 5'h10
    } astx_rx_e;
endpackage

// >>> astx_top.sv
`timescale 1ns/10ps
// What this block does
// - Infrared enable switches pins to infrared use
// - Width code sets infrared transmit pulse width
// - Transmit invert flips output and pulse level
// - Receive invert flips input before decoding
// - Infrared control kept; low two bits read one
// - Frame: start, LSB-first data, parity, stops
// - Independent double-buffered transmitter and receiver
// - Output clock at bit rate, rising mid-bit
// - Transmit disable forces buffer empty flag
// - Receive disable keeps receive flags and data
// - Clock output starts once port bit and low clock enable set, internal clock only
// - Enable sends all-ones frame, receiver idles
// - Empty flag low: load shifter, set flag
// - Empty flag set raises empty request
// - Stop-time flag low chains next frame gaplessly
// - Stop-time flag high: done flag, mark, request
// - Holding write or controller load clears flag
module astx_top
    import astx_pkg::*;
(
    // Clock and reset
    input  wire logic              clk_sys,
    input  wire logic              nrst,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Transfer controller load of the holding register
    input  wire logic              xferWrite,
    input  wire logic [7:0]        xferData,
    // Serial pins
    output logic                   txPin,
    input  wire logic              rxPin,
    input  wire logic              sckIn,
    output logic                   sckOut,
    output logic                   sckOe,
    // Interrupt requests
    output logic                   txEmptyIrq,
    output logic                   txDoneIrq
);
    // Registers
    logic [7:2]  irCtl_reg;         // Infrared control, stored bits
    logic [7:0]  mode_reg;          // Frame format
    logic [7:0]  ctrl_reg;          // Enables and clock select
    logic [7:0]  bitRate_reg;       // Rate divisor
    logic [7:0]  txHold_reg;        // Holding register
    logic [7:0]  rxData_reg;        // Received byte
    logic        tx_buffer_empty_flag_reg, tx_done_flag_reg, rx_full_flag_reg, oer_reg, fer_reg, per_reg;
    logic [31:0] rdData_reg;        // Read data captured in setup
    // Synchronisers and clock recovery
    logic        rxMeta_reg, rxSync_reg, sckMeta_reg, sckSync_reg, sckPrev_reg;
    logic [7:0]  brgCnt_reg;        // Rate counter
    logic        tick16;            // Sixteen-times bit rate tick
    // Transmitter
    astx_tx_e    txState_reg;
    logic [3:0]  txPhase_reg;       // Position within bit
    logic [7:0]  txShift_reg;       // Shift register
    logic [2:0]  txCnt_reg;
    logic        txPar_reg, stopLeft_reg, pre_reg, pendPre_reg, teDly_reg, chain_reg;
    logic [4:0]  irCnt_reg;         // Cycles since bit start
    logic        bitEnd, lastTx, enterStop, loadEvt, tendEvt, txBit, irPulse;
    // Receiver
    astx_rx_e    rxState_reg;
    logic [3:0]  rxPhase_reg;
    logic [7:0]  rxShift_reg;
    logic [2:0]  rxCnt_reg;
    logic        rxParBit_reg;
    logic [3:0]  irHold_reg;        // Stretch of a received pulse
    logic        irIn, rxLine, rxEvt, rxErr, lastRx;
    logic [7:0]  rxByte;
    // Bus decode
    logic [23:0] idx;
    logic        hIr, hMd, hCt, hBr, hTx, hSt, hRx, mapped, wrAcc, rdAcc, txWr;
    logic        te, extClk;

    assign te     = ctrl_reg[CT_TE];
    assign extClk = ctrl_reg[CT_CLOCK_ENABLE_HIGH];
    assign idx    = paddr[ADDR_W-1:2];
    assign hIr    = (idx == IDX_IRCTL);
    assign hMd    = (idx == IDX_MODE);
    assign hCt    = (idx == IDX_CTRL);
    assign hBr    = (idx == IDX_BRATE);
    assign hTx    = (idx == IDX_TXDATA);
    assign hSt    = (idx == IDX_STATUS);
    assign hRx    = (idx == IDX_RXDATA);
    assign mapped = (paddr[1:0] == 2'h0) & (hIr | hMd | hCt | hBr | hTx | hSt | hRx);
    assign wrAcc  = psel & penable & pwrite & mapped;
    assign rdAcc  = psel & penable & ~pwrite & mapped;
    assign txWr   = (wrAcc & hTx) | xferWrite;
    // Zero-wait slave; unmapped or misaligned gives an error
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mapped;
    assign prdata  = rdData_reg;

    // Read data chosen in the setup cycle
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            rdData_reg <= 32'h0;
        end else if (psel & ~penable) begin
            rdData_reg <= 32'h0;
            if (hIr) begin
                rdData_reg[7:0] <= {irCtl_reg, IR_RSVD};
            end
            if (hMd) rdData_reg[7:0] <= mode_reg;
            if (hCt) rdData_reg[7:0] <= ctrl_reg;
            if (hBr) rdData_reg[7:0] <= bitRate_reg;
            if (hTx) rdData_reg[7:0] <= txHold_reg;
            if (hRx) rdData_reg[7:0] <= rxData_reg;
            if (hSt) begin
                rdData_reg[7:2] <= {tx_buffer_empty_flag_reg, rx_full_flag_reg, oer_reg, fer_reg, per_reg, tx_done_flag_reg};
            end
        end
    end

    // Configuration registers; only reset clears them, so standby keeps them
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            irCtl_reg   <= IRCTL_RST[7:2];
            mode_reg    <= 8'h00;
            ctrl_reg    <= 8'h00;
            bitRate_reg <= 8'hFF;
            txHold_reg  <= 8'h00;
        end else begin
            if (wrAcc & hIr) irCtl_reg <= pwdata[7:2];
            if (wrAcc & hMd) mode_reg <= pwdata[7:0];
            if (wrAcc & hCt) ctrl_reg <= pwdata[7:0];
            if (wrAcc & hBr) bitRate_reg <= pwdata[7:0];
            // Controller load takes priority over a bus write
            if (xferWrite) begin
                txHold_reg <= xferData;
            end else if (wrAcc & hTx) begin
                txHold_reg <= pwdata[7:0];
            end
        end
    end

    // Pin synchronisers
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            rxMeta_reg  <= 1'b1;
            rxSync_reg  <= 1'b1;
            sckMeta_reg <= 1'b0;
            sckSync_reg <= 1'b0;
            sckPrev_reg <= 1'b0;
        end else begin
            rxMeta_reg  <= rxPin;
            rxSync_reg  <= rxMeta_reg;
            sckMeta_reg <= sckIn;
            sckSync_reg <= sckMeta_reg;
            sckPrev_reg <= sckSync_reg;
        end
    end

    // Rate counter; external clock edges replace it, even during setup
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            brgCnt_reg <= 8'h00;
        end else begin
            brgCnt_reg <= (brgCnt_reg >= bitRate_reg) ? 8'h00 : brgCnt_reg + 8'h01;
        end
    end
    assign tick16 = extClk ? (sckSync_reg & ~sckPrev_reg)
                           : (brgCnt_reg >= bitRate_reg);

    // Transmit sequencer decode
    assign bitEnd    = tick16 & (txPhase_reg == PH_LAST);
    assign lastTx    = (txCnt_reg == (mode_reg[MD_CHR7] ? 3'h6 : 3'h7));
    assign enterStop = (txState_reg == TX_PAR)
                     | ((txState_reg == TX_DATA) & lastTx & ~mode_reg[MD_PEN]);
    // Load from idle, or at stop time for a gapless next frame
    assign loadEvt = bitEnd & te & ~tx_buffer_empty_flag_reg
                   & (((txState_reg == TX_IDLE) & ~pendPre_reg) | enterStop);
    assign tendEvt = bitEnd & te & tx_buffer_empty_flag_reg & enterStop;

    // Transmit sequencer
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            txState_reg  <= TX_IDLE;
            txPhase_reg  <= 4'h0;
            txShift_reg  <= 8'h00;
            txCnt_reg    <= 3'h0;
            txPar_reg    <= 1'b0;
            stopLeft_reg <= 1'b0;
            pre_reg      <= 1'b0;
            pendPre_reg  <= 1'b0;
            teDly_reg    <= 1'b0;
            chain_reg    <= 1'b0;
        end else begin
            teDly_reg <= te;
            if (tick16) txPhase_reg <= txPhase_reg + 4'h1;
            // Enabling schedules one all-ones frame first
            if (te & ~teDly_reg) pendPre_reg <= 1'b1;
            if (loadEvt) begin
                txShift_reg <= txHold_reg;
                txPar_reg   <= (^(txHold_reg & {~mode_reg[MD_CHR7], 7'h7F})) ^ mode_reg[MD_ODD];
            end
            if (!te) begin
                // Disabled: line at mark
                txState_reg <= TX_IDLE;
                pre_reg     <= 1'b0;
                chain_reg   <= 1'b0;
            end else if (bitEnd) begin
                case (txState_reg)
                    TX_IDLE: begin
                        if (pendPre_reg) begin
                            pendPre_reg <= 1'b0;
                            pre_reg     <= 1'b1;
                            txState_reg <= TX_START;
                        end else if (loadEvt) begin
                            txState_reg <= TX_START;
                        end
                    end
                    TX_START: begin
                        txCnt_reg   <= 3'h0;
                        txState_reg <= TX_DATA;
                    end
                    TX_DATA: begin
                        txCnt_reg <= txCnt_reg + 3'h1;
                        if (!loadEvt) txShift_reg <= {1'b1, txShift_reg[7:1]};
                        if (lastTx) txState_reg <= mode_reg[MD_PEN] ? TX_PAR : TX_STOP;
                    end
                    TX_PAR: begin
                        txState_reg <= TX_STOP;
                    end
                    TX_STOP: begin
                        if (stopLeft_reg) begin
                            stopLeft_reg <= 1'b0;
                        end else begin
                            pre_reg     <= 1'b0;
                            txState_reg <= chain_reg ? TX_START : TX_IDLE;
                        end
                    end
                    default: txState_reg <= TX_IDLE;
                endcase
                if (enterStop) begin
                    stopLeft_reg <= mode_reg[MD_STP2];
                    chain_reg    <= loadEvt;
                end
            end
        end
    end

    // Serial bit; the warm-up frame forces ones
    always_comb begin
        case (txState_reg)
            TX_START: txBit = pre_reg;
            TX_DATA:  txBit = txShift_reg[0] | pre_reg;
            TX_PAR:   txBit = txPar_reg | pre_reg;
            default:  txBit = 1'b1;
        endcase
    end

    // Cycles since the bit began, for fixed infrared widths
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            irCnt_reg <= 5'h00;
        end else if (bitEnd) begin
            irCnt_reg <= 5'h00;
        end else if (irCnt_reg != 5'h1F) begin
            irCnt_reg <= irCnt_reg + 5'h01;
        end
    end

    // Infrared pulse: one per zero bit, width by code
    always_comb begin
        case (irCtl_reg[IR_WLO+2:IR_WLO])
            IRW_D2:  irPulse = irCnt_reg < 5'h02;
            IRW_D4:  irPulse = irCnt_reg < 5'h04;
            IRW_D8:  irPulse = irCnt_reg < 5'h08;
            IRW_D16: irPulse = irCnt_reg < 5'h10;
            default: irPulse = txPhase_reg < IR_BIT_PH;
        endcase
        irPulse = irPulse & ~txBit;
    end

    // Pin drivers; clock output rises at mid-bit
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            txPin  <= 1'b1;
            sckOut <= 1'b0;
            sckOe  <= 1'b0;
        end else begin
            txPin  <= irCtl_reg[IR_EN] ? (irPulse ^ irCtl_reg[IR_TXI]) : txBit;
            sckOut <= txPhase_reg[3];
            sckOe  <= ~extClk & ctrl_reg[CT_CLOCK_ENABLE_LOW] & ctrl_reg[CT_SCKP];
        end
    end

    // Status flags; hardware set wins over clear
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            tx_buffer_empty_flag_reg <= 1'b1;
            tx_done_flag_reg <= 1'b1;
            rx_full_flag_reg <= 1'b0;
            oer_reg  <= 1'b0;
            fer_reg  <= 1'b0;
            per_reg  <= 1'b0;
        end else begin
            if (!te | loadEvt) tx_buffer_empty_flag_reg <= 1'b1;
            else if (txWr) tx_buffer_empty_flag_reg <= 1'b0;
            if (tendEvt) tx_done_flag_reg <= 1'b1;
            else if (txWr | (wrAcc & hSt & ~pwdata[ST_TX_DONE_FLAG])) tx_done_flag_reg <= 1'b0;
            // Receive flags ignore the receive enable
            if (rxEvt & ~rx_full_flag_reg) rx_full_flag_reg <= 1'b1;
            else if ((rdAcc & hRx) | (wrAcc & hSt & ~pwdata[ST_RX_FULL_FLAG])) rx_full_flag_reg <= 1'b0;
            if (rxEvt & rx_full_flag_reg) oer_reg <= 1'b1;
            else if (wrAcc & hSt & ~pwdata[ST_OER]) oer_reg <= 1'b0;
            if (rxEvt & ~rxLine) fer_reg <= 1'b1;
            else if (wrAcc & hSt & ~pwdata[ST_FER]) fer_reg <= 1'b0;
            if (rxEvt & ((^rxByte) ^ mode_reg[MD_ODD] ^ rxParBit_reg) & mode_reg[MD_PEN]) begin
                per_reg <= 1'b1;
            end else if (wrAcc & hSt & ~pwdata[ST_PER]) begin
                per_reg <= 1'b0;
            end
        end
    end
    assign txEmptyIrq = tx_buffer_empty_flag_reg & ctrl_reg[CT_TIE];
    assign txDoneIrq  = tx_done_flag_reg & ctrl_reg[CT_TX_DONE_IRQ_ENABLE];

    // Infrared receive: invert, then stretch each pulse to a zero bit
    assign irIn   = rxSync_reg ^ irCtl_reg[IR_RXI];
    assign rxLine = irCtl_reg[IR_EN] ? (~irIn & (irHold_reg == 4'h0)) : rxSync_reg;
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            irHold_reg <= 4'h0;
        end else if (irIn) begin
            irHold_reg <= PH_LAST;
        end else if (tick16 & (irHold_reg != 4'h0)) begin
            irHold_reg <= irHold_reg - 4'h1;
        end
    end

    // Receive decode
    assign rxErr  = oer_reg | fer_reg | per_reg;
    assign lastRx = (rxCnt_reg == (mode_reg[MD_CHR7] ? 3'h6 : 3'h7));
    assign rxByte = mode_reg[MD_CHR7] ? {1'b0, rxShift_reg[7:1]} : rxShift_reg;
    assign rxEvt  = tick16 & (rxPhase_reg == PH_MID) & (rxState_reg == RX_STOP);

    // Receive sequencer, independent of the transmitter
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            rxState_reg  <= RX_IDLE;
            rxPhase_reg  <= 4'h0;
            rxShift_reg  <= 8'h00;
            rxCnt_reg    <= 3'h0;
            rxParBit_reg <= 1'b0;
        end else if (tick16) begin
            rxPhase_reg <= rxPhase_reg + 4'h1;
            case (rxState_reg)
                RX_IDLE: begin
                    // Wait for a start bit; errors block reception
                    rxPhase_reg <= 4'h0;
                    if (ctrl_reg[CT_RE] & ~rxErr & ~rxLine) rxState_reg <= RX_START;
                end
                RX_START: begin
                    if (rxPhase_reg == PH_MID) begin
                        rxCnt_reg   <= 3'h0;
                        rxState_reg <= rxLine ? RX_IDLE : RX_DATA;
                    end
                end
                RX_DATA: begin
                    if (rxPhase_reg == PH_MID) begin
                        rxShift_reg <= {rxLine, rxShift_reg[7:1]};
                        rxCnt_reg   <= rxCnt_reg + 3'h1;
                        if (lastRx) rxState_reg <= mode_reg[MD_PEN] ? RX_PAR : RX_STOP;
                    end
                end
                RX_PAR: begin
                    if (rxPhase_reg == PH_MID) begin
                        rxParBit_reg <= rxLine;
                        rxState_reg  <= RX_STOP;
                    end
                end
                RX_STOP: begin
                    if (rxPhase_reg == PH_MID) rxState_reg <= RX_IDLE;
                end
                default: rxState_reg <= RX_IDLE;
            endcase
        end
    end

    // Receive buffer loads only when empty
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            rxData_reg <= 8'h00;
        end else if (rxEvt & ~rx_full_flag_reg) begin
            rxData_reg <= rxByte;
        end
    end

    // Checks
    sequence stopLoad;
        bitEnd && enterStop && te && !tx_buffer_empty_flag_reg;
    endsequence
    sequence chainedStop;
        (txState_reg == TX_STOP) && chain_reg && tx_buffer_empty_flag_reg;
    endsequence
    AST_IR_RSVD: assert property (@(posedge clk_sys) disable iff (!nrst)
        (psel && !penable && hIr && paddr[1:0] == 2'h0) |=> prdata[1:0] == IR_RSVD)
        else $error("reserved bits not one");
    AST_TE_OFF: assert property (@(posedge clk_sys) disable iff (!nrst)
        !te |=> tx_buffer_empty_flag_reg) else $error("empty flag not forced");
    AST_WR_CLR: assert property (@(posedge clk_sys) disable iff (!nrst)
        (txWr && te && !loadEvt) |=> !tx_buffer_empty_flag_reg) else $error("write did not clear empty");
    AST_CHAIN: assert property (@(posedge clk_sys) disable iff (!nrst)
        stopLoad |=> chainedStop) else $error("no gapless chain");
    AST_TX_DONE_FLAG: assert property (@(posedge clk_sys) disable iff (!nrst)
        tendEvt |=> tx_done_flag_reg && txState_reg == TX_STOP && !chain_reg)
        else $error("done flag missing");
    AST_TXI: assert property (@(posedge clk_sys) disable iff (!nrst)
        (loadEvt && ctrl_reg[CT_TIE]) |=> txEmptyIrq) else $error("empty request missing");
    AST_START: assert property (@(posedge clk_sys) disable iff (!nrst)
        (txState_reg == TX_START && !pre_reg && !irCtl_reg[IR_EN]) |=> !txPin)
        else $error("start bit not low");
    AST_IR_ONE: assert property (@(posedge clk_sys) disable iff (!nrst)
        (irCtl_reg[IR_EN] && txBit) |=> txPin == $past(irCtl_reg[IR_TXI]))
        else $error("pulse on one bit");
    AST_RE_OFF: assert property (@(posedge clk_sys) disable iff (!nrst)
        ($fell(ctrl_reg[CT_RE]) && !rxEvt && !psel) |=> $stable(rx_full_flag_reg) && $stable(rxData_reg))
        else $error("receive state disturbed");
    AST_SCK: assert property (@(posedge clk_sys) disable iff (!nrst)
        (tick16 && txPhase_reg == PH_MID) |-> ##2 sckOut)
        else $error("clock not high after mid-bit");
    AST_SCK_LO: assert property (@(posedge clk_sys) disable iff (!nrst)
        bitEnd |-> ##2 !sckOut)
        else $error("clock not low after bit start");
endmodule

// >>> astx_line_model.sv
`timescale 1ns/10ps
// Far end of the serial line: echoes the transmit line back as receive data
module astx_line_model (
    // Clock
    input  wire logic clk_sys,
    // Line from the block
    input  wire logic txPin,
    // Lines into the block
    output logic      rxPin,
    output logic      sckIn
);
    // Loop the line back one cycle late, like a short cable to a mirror end
    always_ff @(posedge clk_sys) begin
        rxPin <= txPin;
    end
    // Sixteen-times clock, free-running from time zero so it also runs during setup
    initial begin
        sckIn = 1'b0;
        forever #5 sckIn = ~sckIn;
    end
endmodule

// >>> async_serial_tx_with_irda_bench.sv
`timescale 1ns/10ps
// Compare helper: counts every compare, reports and counts mismatches
`define CHK(nm, ex, gt) begin checks_done++; if ((gt) !== (ex)) begin fail_count++; \
    $display("[ERR] %s expected %0h seen %0h", nm, ex, gt); end end
module async_serial_tx_with_irda_bench import astx_pkg::*;;
    logic              clk_sys, nrst, psel, penable, pwrite, xferWrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata, prdata;
    logic              pready, pslverr, txPin, rxPin, sckIn, sckOut, sckOe;
    logic              txEmptyIrq, txDoneIrq, er;
    logic [7:0]        xferData, rd;
    int                fail_count, checks_done;
    astx_top i_astx_top (.clk_sys(clk_sys), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .xferWrite(xferWrite), .xferData(xferData), .txPin(txPin),
        .rxPin(rxPin), .sckIn(sckIn), .sckOut(sckOut), .sckOe(sckOe),
        .txEmptyIrq(txEmptyIrq), .txDoneIrq(txDoneIrq));
    astx_line_model i_astx_line_model (.clk_sys(clk_sys), .txPin(txPin), .rxPin(rxPin),
        .sckIn(sckIn));
    // 200 MHz clock
    always #2.5 clk_sys = ~clk_sys;
    // Verdict and end of run
    task automatic print_verdict;
        if (fail_count == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // One APB transfer, held until pready is seen high
    task automatic apb(input logic w, input logic [23:0] idx, input logic [7:0] d);
        int n;
        @(posedge clk_sys);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= {idx, 2'b00};
        pwdata  <= {24'h0, d};
        @(posedge clk_sys);
        penable <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk_sys);
            if (pready === 1'b1) break;
        end
        rd = prdata[7:0];
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n == 50) begin fail_count++; print_verdict; end
    endtask
    // Wait for a start bit, then sample nb bits at mid-bit (bl clocks a bit)
    task automatic grab(input int nb, input int bl, output logic [19:0] b, output int lead);
        lead = 0;
        b = '0;
        while (txPin !== 1'b0) begin
            @(posedge clk_sys);
            lead++;
            if (lead > 600) begin fail_count++; print_verdict; end
        end
        repeat (bl / 2) @(posedge clk_sys);
        for (int i = 0; i < nb; i++) begin
            b[i] = txPin;
            repeat (bl) @(posedge clk_sys);
        end
    endtask
    // Count clocks at level lvl over a 240-clock window, longer than a frame
    task automatic count(input logic lvl, output int c);
        c = 0;
        repeat (240) begin
            @(posedge clk_sys);
            if (txPin === lvl) c++;
        end
    endtask
    // Reset values, register access, disabled transmitter, unmapped address
    task automatic t_regs;
        apb(1'b0, IDX_IRCTL, 8'h00);
        `CHK("irctlRst", IRCTL_RST, rd)
        apb(1'b0, IDX_STATUS, 8'h00);
        `CHK("statRst", 8'h84, rd)
        apb(1'b1, IDX_IRCTL, 8'h7C);
        apb(1'b0, IDX_IRCTL, 8'h00);
        `CHK("irctlRw", 8'h7F, rd)
        apb(1'b1, IDX_TXDATA, 8'h11);
        apb(1'b0, IDX_STATUS, 8'h00);
        `CHK("teOff", 1'b1, rd[ST_TX_BUFFER_EMPTY_FLAG])
        apb(1'b0, 24'hFF05DF, 8'h00);
        `CHK("unmapped", 1'b1, er)
        apb(1'b1, IDX_IRCTL, 8'h03);
    endtask
    // Enable, lead frame, two chained frames, loopback receive with overrun
    task automatic t_chain;
        logic [19:0] b;
        int          lead;
        apb(1'b1, IDX_BRATE, 8'h00);
        repeat (16) @(posedge clk_sys);
        apb(1'b1, IDX_CTRL, 8'hBD);
        fork
            grab(20, 16, b, lead);
            begin
                apb(1'b1, IDX_TXDATA, 8'hA5);
                rd = 8'h00;
                for (int k = 0; k < 100 && rd[ST_TX_BUFFER_EMPTY_FLAG] !== 1'b1; k++) apb(1'b0, IDX_STATUS, 8'h00);
                `CHK("txEmptyIrq", 1'b1, txEmptyIrq)
                apb(1'b1, IDX_TXDATA, 8'h3C);
            end
        join
        `CHK("frames", {1'b1, 8'h3C, 1'b0, 1'b1, 8'hA5, 1'b0}, b)
        `CHK("sckOe", 1'b1, sckOe)
        `CHK("lead", 1'b1, lead >= 150)
        repeat (32) @(posedge clk_sys);
        apb(1'b0, IDX_STATUS, 8'h00);
        `CHK("done", 1'b1, rd[ST_TX_DONE_FLAG])
        `CHK("overrun", 1'b1, rd[ST_OER])
        `CHK("txDoneIrq", 1'b1, txDoneIrq)
        apb(1'b0, IDX_RXDATA, 8'h00);
        `CHK("rxData", 8'hA5, rd)
        apb(1'b1, IDX_CTRL, 8'hA8);
        apb(1'b0, IDX_STATUS, 8'h00);
        `CHK("rxKept", 1'b1, rd[ST_OER])
    endtask
    // Transfer controller load starts a frame by itself
    task automatic t_xfer;
        logic [19:0] b;
        int          lead;
        fork
            grab(10, 16, b, lead);
            begin
                xferData  <= 8'h5A;
                xferWrite <= 1'b1;
                @(posedge clk_sys);
                xferWrite <= 1'b0;
            end
        join
        `CHK("xferFrame", 10'h2B4, b[9:0])
    endtask
    // External sixteen-times clock paces a frame, 32 clocks a bit
    task automatic t_ext;
        logic [19:0] b;
        int          lead;
        apb(1'b1, IDX_CTRL, 8'hA2);
        repeat (40) @(posedge clk_sys);
        fork
            grab(10, 32, b, lead);
            apb(1'b1, IDX_TXDATA, 8'hC3);
        join
        `CHK("extFrame", {1'b1, 8'hC3, 1'b0}, b[9:0])
        apb(1'b1, IDX_CTRL, 8'hA8);
    endtask
    // Infrared pulses: width codes 001 and 000, plain, inverted, looped back
    task automatic t_irda;
        int c;
        repeat (16) @(posedge clk_sys);
        apb(1'b1, IDX_IRCTL, 8'h93);
        apb(1'b1, IDX_TXDATA, 8'hFE);
        count(1'b1, c);
        `CHK("irHigh", 4, c)
        apb(1'b1, IDX_IRCTL, 8'h83);
        apb(1'b1, IDX_TXDATA, 8'hFE);
        count(1'b1, c);
        `CHK("irWide", 6, c)
        apb(1'b1, IDX_IRCTL, 8'h9F);
        apb(1'b1, IDX_TXDATA, 8'hFE);
        count(1'b0, c);
        `CHK("irLow", 4, c)
        apb(1'b1, IDX_STATUS, 8'h00);
        apb(1'b1, IDX_CTRL, 8'hB8);
        apb(1'b1, IDX_TXDATA, 8'h96);
        count(1'b0, c);
        `CHK("irLowRx", 10, c)
        apb(1'b0, IDX_RXDATA, 8'h00);
        `CHK("irRx", 8'h96, rd)
        apb(1'b1, IDX_CTRL, 8'h00);
        apb(1'b0, IDX_STATUS, 8'h00);
        `CHK("teOffEnd", 1'b1, rd[ST_TX_BUFFER_EMPTY_FLAG])
    endtask
    // Main sequence
    initial begin
        {clk_sys, nrst, psel, penable, pwrite, xferWrite} = '0;
        paddr = '0;
        pwdata = '0;
        xferData = '0;
        fail_count = 0;
        checks_done = 0;
        repeat (20) @(posedge clk_sys);
        nrst <= 1'b1;
        t_regs;
        t_chain;
        t_xfer;
        t_ext;
        t_irda;
        print_verdict;
    end
endmodule
